// file: hdl/hisr_pkg.sv
package hisr_pkg;

  // Register byte addresses on the Avalon-MM slave.
  localparam logic [9:0]  HISR_STATUS_ADDR   = 10'h310;
  localparam logic [9:0]  HISR_ENABLE_ADDR   = 10'h314;
  localparam logic [9:0]  HISR_WAKE_ADDR     = 10'h354;
  localparam logic [9:0]  HISR_STATE_ADDR    = 10'h318;

  // Flag bit positions.
  localparam int HISR_OTG_BIT    = 10;
  localparam int HISR_ISO_BIT    = 9;
  localparam int HISR_ASYNC_BIT  = 8;
  localparam int HISR_PINT_BIT   = 7;
  localparam int HISR_CLK_BIT    = 6;
  localparam int HISR_SUSP_BIT   = 5;
  localparam int HISR_DMA_BIT    = 3;
  localparam int HISR_SOF_BIT    = 1;
  localparam int HISR_RSV2_BIT   = 2;
  localparam int HISR_RSV0_BIT   = 0;

  // Mask of flags that hardware sets and software clears.
  localparam logic [31:0] HISR_FLAG_MASK     = 32'h000007EA;
  // Reset values.
  localparam logic [31:0] HISR_STATUS_RST    = 32'h00000000;
  localparam logic [31:0] HISR_ENABLE_RST    = 32'h00000000;
  localparam logic [15:0] HISR_WAKE_RST      = 16'h0190;

  // Delay before reserved bits 2 and 0 rise after reset.
  localparam int          HISR_RSV_DELAY_NS  = 1000;
  localparam int          HISR_CLK_NS        = 25;
  localparam logic [7:0]  HISR_RSV_CYCLES    = 8'((HISR_RSV_DELAY_NS + HISR_CLK_NS - 1) / HISR_CLK_NS);

  // Wake-up counter unit: one count per microsecond at 40 MHz.
  localparam int          HISR_WAKE_UNIT_NS  = 1000;
  localparam logic [5:0]  HISR_WAKE_PRESCALE = 6'(HISR_WAKE_UNIT_NS / HISR_CLK_NS);

endpackage : hisr_pkg

// file: hdl/hisr_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Set bit 10 on on-the-go event.
// - Set bit 9 on isochronous descriptor done.
// - Set bit 8 on async list descriptor done.
// - Set bit 7 on interrupt descriptor done.
// - Mask-combination completion also sets list flags.
// - Set bit 6 when clocks run stable.
// - Set bit 5 on suspend entry.
// - Bus access in suspend wakes programmed time.
// - Set bit 3 on DMA completion.
// - Set bit 1 on start-of-frame.
// - Interrupt only when flag and enable set.
// - Reserved bits 2,0 rise shortly after reset.
// - Writing one clears flag, zero keeps it.
// - Flags set regardless of master enable.
module hisr_top
  import hisr_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Avalon-MM slave.
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Event pulses and the suspended level from the host controller logic.
  input  wire logic        otg_event,
  input  wire logic        iso_done,
  input  wire logic        iso_mask_done,
  input  wire logic        async_done,
  input  wire logic        async_mask_done,
  input  wire logic        periodic_int_done,
  input  wire logic        periodic_int_mask_done,
  input  wire logic        clock_stable,
  input  wire logic        suspend_enter,
  input  wire logic        dma_end,
  input  wire logic        frame_start,
  input  wire logic        suspended,
  // Interrupt and wake outputs.
  output logic             irq,
  output logic             wake_request
);

  import hisr_pkg::*;

  typedef struct packed {
    logic [31:0] status;
    logic [31:0] enable;
    logic [15:0] wake_time;
    logic [7:0]  rsv_cnt;
    logic        rsv_high;
    logic        clk_stable_d;
    logic        susp_d;
    logic        ack;
    logic [31:0] rdata;
    logic        irq;
    logic        wake;
  } hisr_state_t;

  hisr_state_t s_r;
  hisr_state_t s_nxt;
  logic        wake_start;
  logic        wake_awake;

  // Byte-enable merge for writable registers.
  function automatic logic [31:0] hisr_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : hisr_merge

  // Expands byte enables into a bit mask.
  function automatic logic [31:0] hisr_be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = 8'hFF;
      end
    end
    return m;
  endfunction : hisr_be_mask

  logic [31:0] ev_set;
  logic [31:0] clr_mask;
  logic        acc;
  logic        acc_now;
  logic [31:0] wake_merged;

  // The wake time sits in the upper half of its word, so the merge is done on the full word first.
  assign wake_merged = hisr_merge({s_r.wake_time, 16'h0000}, avs_writedata, avs_byteenable);

  // Collects the event pulses into their flag positions.
  always_comb begin
    ev_set = 32'h00000000;
    ev_set[HISR_OTG_BIT]   = otg_event;
    ev_set[HISR_ISO_BIT]   = iso_done | iso_mask_done;
    ev_set[HISR_ASYNC_BIT] = async_done | async_mask_done;
    ev_set[HISR_PINT_BIT]  = periodic_int_done | periodic_int_mask_done;
    ev_set[HISR_CLK_BIT]   = clock_stable & ~s_r.clk_stable_d;
    ev_set[HISR_SUSP_BIT]  = suspend_enter & ~s_r.susp_d;
    ev_set[HISR_DMA_BIT]   = dma_end;
    ev_set[HISR_SOF_BIT]   = frame_start;
  end

  assign acc      = (avs_read | avs_write) & ~s_r.ack;
  assign acc_now  = acc;
  assign clr_mask = (acc && avs_write && avs_address == HISR_STATUS_ADDR) ?
                    (avs_writedata & hisr_be_mask(avs_byteenable) & HISR_FLAG_MASK) : 32'h00000000;
  assign wake_start = acc_now & suspended;

  // Next-state logic: flags, enables, bus answer and interrupt.
  always_comb begin
    s_nxt = s_r;
    s_nxt.clk_stable_d = clock_stable;
    s_nxt.susp_d       = suspend_enter;
    // Reserved bits rise after a fixed delay from reset release.
    if (!s_r.rsv_high) begin
      if (s_r.rsv_cnt >= HISR_RSV_CYCLES - 8'h01) begin
        s_nxt.rsv_high = 1'b1;
      end else begin
        s_nxt.rsv_cnt = s_r.rsv_cnt + 8'h01;
      end
    end
    // Set wins over clear; flags are set regardless of any master enable.
    s_nxt.status = ((s_r.status & ~clr_mask) | ev_set) & HISR_FLAG_MASK;
    s_nxt.status[HISR_RSV2_BIT] = s_nxt.rsv_high;
    s_nxt.status[HISR_RSV0_BIT] = s_nxt.rsv_high;
    // One-cycle answer: wait asserted until the ack cycle.
    s_nxt.ack   = acc;
    s_nxt.rdata = 32'h00000000;
    if (acc && avs_write && avs_address == HISR_ENABLE_ADDR) begin
      s_nxt.enable = hisr_merge(s_r.enable, avs_writedata, avs_byteenable) & HISR_FLAG_MASK;
    end
    if (acc && avs_write && avs_address == HISR_WAKE_ADDR) begin
      s_nxt.wake_time = wake_merged[31:16];
    end
    if (acc && avs_read) begin
      unique case (avs_address)
        HISR_STATUS_ADDR: s_nxt.rdata = s_r.status;
        HISR_ENABLE_ADDR: s_nxt.rdata = s_r.enable;
        HISR_WAKE_ADDR:   s_nxt.rdata = {s_r.wake_time, 16'h0000};
        HISR_STATE_ADDR:  s_nxt.rdata = {30'h00000000, wake_awake, suspended};
        default:          s_nxt.rdata = 32'h00000000;
      endcase
    end
    s_nxt.irq  = |(s_nxt.status & s_nxt.enable & HISR_FLAG_MASK);
    s_nxt.wake = wake_awake | wake_start;
  end

  // State register.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.wake_time <= HISR_WAKE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Wake-up duration timer.
  hisr_wake_timer u_wake (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .start    (wake_start),
    .duration (s_r.wake_time),
    .awake    (wake_awake)
  );

  assign avs_readdata    = s_r.rdata;
  assign avs_waitrequest = ~s_r.ack;
  assign irq             = s_r.irq;
  assign wake_request    = s_r.wake;

  // Assertions.
  sequence s_en_flag;
    |(s_r.status & s_r.enable & HISR_FLAG_MASK);
  endsequence

  property p_irq_set;
    @(posedge clk_sys) disable iff (!nrst) s_en_flag |-> irq;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq low with enabled flag");

  property p_irq_clr;
    @(posedge clk_sys) disable iff (!nrst) !s_en_flag |-> !irq;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq high without enabled flag");

  property p_otg;
    @(posedge clk_sys) disable iff (!nrst) otg_event |=> s_r.status[HISR_OTG_BIT];
  endproperty
  a_otg: assert property (p_otg) else $error("otg flag not set");

  property p_iso;
    @(posedge clk_sys) disable iff (!nrst) (iso_done | iso_mask_done) |=> s_r.status[HISR_ISO_BIT];
  endproperty
  a_iso: assert property (p_iso) else $error("iso flag not set");

  property p_async;
    @(posedge clk_sys) disable iff (!nrst) (async_done | async_mask_done) |=> s_r.status[HISR_ASYNC_BIT];
  endproperty
  a_async: assert property (p_async) else $error("async flag not set");

  property p_pint;
    @(posedge clk_sys) disable iff (!nrst) periodic_int_mask_done |=> s_r.status[HISR_PINT_BIT];
  endproperty
  a_pint: assert property (p_pint) else $error("periodic flag not set");

  property p_dma;
    @(posedge clk_sys) disable iff (!nrst) dma_end |=> s_r.status[HISR_DMA_BIT];
  endproperty
  a_dma: assert property (p_dma) else $error("dma flag not set");

  property p_sof;
    @(posedge clk_sys) disable iff (!nrst) frame_start |=> s_r.status[HISR_SOF_BIT];
  endproperty
  a_sof: assert property (p_sof) else $error("sof flag not set");

  property p_sticky;
    @(posedge clk_sys) disable iff (!nrst) (s_r.status[HISR_DMA_BIT] && clr_mask[HISR_DMA_BIT] == 1'b0)
      |=> s_r.status[HISR_DMA_BIT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without clear");

  property p_clear;
    @(posedge clk_sys) disable iff (!nrst) (clr_mask[HISR_SOF_BIT] && !frame_start) |=> !s_r.status[HISR_SOF_BIT];
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared by write one");

  property p_wake;
    @(posedge clk_sys) disable iff (!nrst) wake_start |=> wake_request [*2];
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on suspended access");

  property p_rsv;
    @(posedge clk_sys) disable iff (!nrst) s_r.rsv_high |-> (s_r.status[HISR_RSV0_BIT] && s_r.status[HISR_RSV2_BIT]);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not high");

  // A plain interrupt descriptor completion sets its flag too.
  property p_pint_done;
    @(posedge clk_sys) disable iff (!nrst) periodic_int_done |=> s_r.status[HISR_PINT_BIT];
  endproperty
  a_pint_done: assert property (p_pint_done) else $error("interrupt list flag not set");

  // A mask-combination completion on the isochronous list sets its flag.
  property p_iso_mask;
    @(posedge clk_sys) disable iff (!nrst) iso_mask_done |=> s_r.status[HISR_ISO_BIT];
  endproperty
  a_iso_mask: assert property (p_iso_mask) else $error("iso mask flag not set");

  // A mask-combination completion on the async list sets its flag.
  property p_async_mask;
    @(posedge clk_sys) disable iff (!nrst) async_mask_done |=> s_r.status[HISR_ASYNC_BIT];
  endproperty
  a_async_mask: assert property (p_async_mask) else $error("async mask flag not set");

  // The rising edge of the clock-stable level sets its flag.
  property p_clk_rise;
    @(posedge clk_sys) disable iff (!nrst) (clock_stable && !s_r.clk_stable_d) |=> s_r.status[HISR_CLK_BIT];
  endproperty
  a_clk_rise: assert property (p_clk_rise) else $error("clock stable flag not set");

  // The rising edge of the suspend level sets its flag.
  property p_susp_rise;
    @(posedge clk_sys) disable iff (!nrst) (suspend_enter && !s_r.susp_d) |=> s_r.status[HISR_SUSP_BIT];
  endproperty
  a_susp_rise: assert property (p_susp_rise) else $error("suspend flag not set");

  // An event in the same cycle as its clear keeps the flag set.
  property p_set_wins;
    @(posedge clk_sys) disable iff (!nrst) (clr_mask[HISR_OTG_BIT] && otg_event) |=> s_r.status[HISR_OTG_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost against clear");

  // Every flag written with one and not set again in that cycle reads zero.
  property p_write_clear;
    @(posedge clk_sys) disable iff (!nrst) (acc && avs_write && avs_address == HISR_STATUS_ADDR)
      |=> ((s_r.status & $past(clr_mask) & ~$past(ev_set)) == 32'h00000000);
  endproperty
  a_write_clear: assert property (p_write_clear) else $error("written flag not cleared");

  // A flag never rises without its event.
  property p_no_spurious;
    @(posedge clk_sys) disable iff (!nrst) (!s_r.status[HISR_OTG_BIT] && !otg_event) |=> !s_r.status[HISR_OTG_BIT];
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("flag rose without event");

  // Reserved bits read zero until the rise delay has run out.
  property p_rsv_low;
    @(posedge clk_sys) disable iff (!nrst) !s_r.rsv_high |-> (!s_r.status[HISR_RSV0_BIT] && !s_r.status[HISR_RSV2_BIT]);
  endproperty
  a_rsv_low: assert property (p_rsv_low) else $error("reserved bits high too early");

  // Once risen, the reserved bits stay high until the next reset.
  property p_rsv_stay;
    @(posedge clk_sys) disable iff (!nrst) s_r.rsv_high |=> s_r.rsv_high;
  endproperty
  a_rsv_stay: assert property (p_rsv_stay) else $error("reserved bits fell");

  // A full-word enable write lands with only the flag positions kept.
  property p_en_write;
    @(posedge clk_sys) disable iff (!nrst)
      (acc && avs_write && avs_address == HISR_ENABLE_ADDR && avs_byteenable == 4'hF)
      |=> (s_r.enable == ($past(avs_writedata) & HISR_FLAG_MASK));
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write did not land");

  // The enable register changes only on a write to its address.
  property p_en_stable;
    @(posedge clk_sys) disable iff (!nrst) !(acc && avs_write && avs_address == HISR_ENABLE_ADDR)
      |=> $stable(s_r.enable);
  endproperty
  a_en_stable: assert property (p_en_stable) else $error("enable changed without write");

  // Enable bits exist only at flag positions.
  property p_en_mask;
    @(posedge clk_sys) disable iff (!nrst) (s_r.enable & ~HISR_FLAG_MASK) == 32'h00000000;
  endproperty
  a_en_mask: assert property (p_en_mask) else $error("enable bit outside flag positions");

  // An enabled event raises the interrupt with its flag.
  property p_irq_event;
    @(posedge clk_sys) disable iff (!nrst) (dma_end && s_r.enable[HISR_DMA_BIT]) |=> irq;
  endproperty
  a_irq_event: assert property (p_irq_event) else $error("enabled event gave no interrupt");

  // The wake output follows the running timer one cycle later.
  property p_wake_hold;
    @(posedge clk_sys) disable iff (!nrst) wake_awake |=> wake_request;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake dropped while timer runs");

endmodule : hisr_top

// file: hdl/hisr_wake_timer.sv
`timescale 1ns/1ps
module hisr_wake_timer
  import hisr_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Control.
  input  wire logic        start,
  input  wire logic [15:0] duration,
  // Status.
  output logic             awake
);

  typedef struct packed {
    logic [5:0]  pre;
    logic [15:0] cnt;
    logic        awake;
  } hisr_wt_state_t;

  hisr_wt_state_t s_r;
  hisr_wt_state_t s_nxt;

  // Counts the programmed duration in microsecond steps after each start.
  always_comb begin
    s_nxt = s_r;
    if (start) begin
      s_nxt.awake = 1'b1;
      s_nxt.cnt   = duration;
      s_nxt.pre   = HISR_WAKE_PRESCALE;
    end else if (s_r.awake) begin
      if (s_r.pre > 6'h01) begin
        s_nxt.pre = s_r.pre - 6'h01;
      end else begin
        s_nxt.pre = HISR_WAKE_PRESCALE;
        if (s_r.cnt <= 16'h0001) begin
          s_nxt.awake = 1'b0;
          s_nxt.cnt   = 16'h0000;
        end else begin
          s_nxt.cnt = s_r.cnt - 16'h0001;
        end
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awake = s_r.awake;

endmodule : hisr_wake_timer

// file: tb/hisr_host_model.sv
`timescale 1ns/1ps
module hisr_host_model (
  // Clock.
  input  wire logic        clk_sys,
  // Avalon-MM master side.
  output logic [9:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  import hisr_pkg::*;

  // Bus idles with no request at time zero.
  initial begin
    avs_address    = '0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = '0;
    avs_byteenable = 4'hF;
  end

  // One bus cycle; the request stands until waitrequest is sampled low.
  task automatic bus_cycle(input logic wr, input logic [9:0] addr, input logic [31:0] data,
                           output logic [31:0] rdata, output logic ok);
    int n;
    n     = 0;
    ok    = 1'b0;
    rdata = '0;
    @(posedge clk_sys);
    avs_address <= addr;
    avs_read    <= !wr;
    avs_write   <= wr;
    // Reserved bits of status and enable writes always carry their reset value of zero.
    if (addr == HISR_STATUS_ADDR || addr == HISR_ENABLE_ADDR) avs_writedata <= data & HISR_FLAG_MASK;
    else avs_writedata <= data;
    while (!ok && n < 100) begin
      @(posedge clk_sys);
      n++;
      if (avs_waitrequest === 1'b0) begin
        ok    = 1'b1;
        rdata = avs_readdata;
      end
    end
    // Clearing is done by writing ones, released data shows no stale value.
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    avs_writedata <= ~data;
  endtask : bus_cycle
endmodule : hisr_host_model

// file: tb/hisr_top_bench.sv
`timescale 1ns/1ps
module hisr_top_bench;
  import hisr_pkg::*;

  logic        clk_sys;
  logic        nrst;
  logic [9:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [10:0] ev;
  logic        suspended;
  logic        irq;
  logic        wake_request;
  int          n_errors;
  int          compares;
  int          n;
  logic [31:0] bitv;
  // Flag position for each event input, in the order of the ev vector.
  int          ev_bit [11] = '{10, 9, 9, 8, 8, 7, 7, 6, 5, 3, 1};

  // Clock at 40 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  hisr_host_model i_host (
    .clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );

  hisr_top i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .otg_event(ev[0]),
    .iso_done(ev[1]), .iso_mask_done(ev[2]), .async_done(ev[3]), .async_mask_done(ev[4]),
    .periodic_int_done(ev[5]), .periodic_int_mask_done(ev[6]), .clock_stable(ev[7]),
    .suspend_enter(ev[8]), .dma_end(ev[9]), .frame_start(ev[10]), .suspended(suspended),
    .irq(irq), .wake_request(wake_request)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // Compares a seen value with the expected one.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Bus access; a cycle that never ends closes the run.
  task automatic access(input logic wr, input logic [9:0] a, input logic [31:0] d, input logic [31:0] exp);
    logic [31:0] r;
    logic        ok;
    i_host.bus_cycle(wr, a, d, r, ok);
    if (ok !== 1'b1) begin
      n_errors++;
      give_verdict();
    end
    if (!wr) check(r, exp);
  endtask : access

  // Raises one event input for a single cycle.
  task automatic pulse(input int i);
    @(posedge clk_sys);
    ev <= 11'(1) << i;
    @(posedge clk_sys);
    ev <= '0;
  endtask : pulse

  // Watchdog against a hang.
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    give_verdict();
  end

  // Main sequence.
  initial begin
    n_errors  = 0;
    compares  = 0;
    nrst      = 1'b0;
    ev        = '0;
    suspended = 1'b0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    access(0, HISR_STATUS_ADDR, 0, HISR_STATUS_RST);
    access(0, HISR_ENABLE_ADDR, 0, HISR_ENABLE_RST);
    check(irq, 0);
    repeat (45) @(posedge clk_sys);
    access(0, HISR_STATUS_ADDR, 0, 32'h00000005);
    for (int i = 0; i < 11; i++) begin
      bitv = 32'h1 << ev_bit[i];
      pulse(i);
      access(0, HISR_STATUS_ADDR, 0, bitv | 32'h5);
      check(irq, 0);
      access(1, HISR_STATUS_ADDR, 32'h0, 0);
      access(0, HISR_STATUS_ADDR, 0, bitv | 32'h5);
      access(1, HISR_STATUS_ADDR, bitv, 0);
      access(0, HISR_STATUS_ADDR, 0, 32'h00000005);
    end
    access(1, HISR_ENABLE_ADDR, 32'hFFFFFFFF, 0);
    access(0, HISR_ENABLE_ADDR, 0, HISR_FLAG_MASK);
    access(1, HISR_ENABLE_ADDR, 32'h1 << HISR_DMA_BIT, 0);
    pulse(9);
    @(posedge clk_sys);
    check(irq, 1);
    pulse(10);
    access(1, HISR_STATUS_ADDR, 32'h1 << HISR_DMA_BIT, 0);
    @(posedge clk_sys);
    check(irq, 0);
    access(1, HISR_ENABLE_ADDR, 32'h1 << HISR_SOF_BIT, 0);
    @(posedge clk_sys);
    check(irq, 1);
    access(1, HISR_STATUS_ADDR, 32'h1 << HISR_SOF_BIT, 0);
    @(posedge clk_sys);
    check(irq, 0);
    access(0, 10'h100, 0, 32'h0);
    // Wake time of 2 counts of 40 cycles each.
    access(1, HISR_WAKE_ADDR, 32'h00020000, 0);
    @(posedge clk_sys);
    check(wake_request, 0);
    suspended <= 1'b1;
    access(0, HISR_STATUS_ADDR, 0, 32'h00000005);
    @(posedge clk_sys);
    check(wake_request, 1);
    n = 0;
    while (wake_request === 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    check(32'(n >= 70 && n <= 90), 1);
    suspended <= 1'b0;
    access(0, HISR_STATUS_ADDR, 0, 32'h00000005);
    @(posedge clk_sys);
    check(wake_request, 0);
    give_verdict();
  end
endmodule : hisr_top_bench
